// File: core/ocpwm_pkg.sv
/*
  ocpwm_pkg: register offsets, field positions, reset values and mode codes
  for the output compare / pwm channel.
  assumes a 16-bit register port addressed by register index.
*/
package ocpwm_pkg;
  localparam int                  OCPWM_AW          = 3;
  localparam int                  OCPWM_DW          = 16;
  // register indices
  localparam logic [OCPWM_AW-1:0] OCPWM_A_CTRL      = 3'h0;
  localparam logic [OCPWM_AW-1:0] OCPWM_A_PRI       = 3'h1;
  localparam logic [OCPWM_AW-1:0] OCPWM_A_SEC       = 3'h2;
  localparam logic [OCPWM_AW-1:0] OCPWM_A_ISTAT     = 3'h3;
  localparam logic [OCPWM_AW-1:0] OCPWM_A_IMASK     = 3'h4;
  localparam logic [OCPWM_AW-1:0] OCPWM_A_OUT       = 3'h5;
  // control field positions
  localparam int                  OCPWM_B_MODE_LO   = 0;
  localparam int                  OCPWM_B_TSEL      = 3;
  localparam int                  OCPWM_B_FLT       = 4;
  localparam int                  OCPWM_B_SIDL      = 13;
  // interrupt status bits
  localparam int                  OCPWM_I_CMP       = 0;
  localparam int                  OCPWM_I_FAULT     = 1;
  localparam int                  OCPWM_IW          = 2;
  localparam logic [15:0]         OCPWM_RST_WORD    = 16'h0000;
  localparam logic [15:0]         OCPWM_ZERO        = 16'h0000;

  typedef enum logic [2:0] {
    OCPWM_M_OFF    = 3'h0,
    OCPWM_M_RISE   = 3'h1,
    OCPWM_M_FALL   = 3'h2,
    OCPWM_M_TOGGLE = 3'h3,
    OCPWM_M_SINGLE = 3'h4,
    OCPWM_M_CONT   = 3'h5,
    OCPWM_M_PWM    = 3'h6,
    OCPWM_M_PWMF   = 3'h7
  } ocpwm_mode_t;
endpackage

// File: core/ocpwm_channel.sv
/*
  ocpwm_channel: one output compare channel with one-shot, toggle, pulse
  and pwm modes, fault protection and a masked interrupt.
  assumes both time bases, their period matches and the cpu idle level
  come from logic on mclk; fault pins are asynchronous and are synchronised.
*/
`timescale 1ns/10ps

module ocpwm_channel
  import ocpwm_pkg::*;
#(
  parameter int CHANNEL = 1
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [ocpwm_pkg::OCPWM_AW-1:0] addr,
  input  wire logic [ocpwm_pkg::OCPWM_DW-1:0] wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [ocpwm_pkg::OCPWM_DW-1:0] rdata,
  input  wire logic [15:0]                 timebase_two,
  input  wire logic [15:0]                 timebase_three,
  input  wire logic                        period_two,
  input  wire logic                        period_three,
  input  wire logic                        cpu_idle,
  input  wire logic                        fault_input_a,
  input  wire logic                        fault_input_b,
  output logic                             compare_output_pin,
  output logic                             pin_owned,
  output logic                             irq
);
  import ocpwm_pkg::*;

  // the channel number picks the fault pin, so only eight channels make sense
  if (CHANNEL < 1 || CHANNEL > 8) begin : bad_channel
    $error("ocpwm_channel: CHANNEL must be 1 to 8");
  end

  // control fields
  logic [2:0]           mode_select_field;
  logic                 timebase_select;
  logic                 idle_halt_bit;
  logic                 fault_status_flag;
  logic [15:0]          primary_compare_value;
  logic [15:0]          secondary_compare_value;
  logic [15:0]          duty;
  logic [OCPWM_IW-1:0]  istat;
  logic [OCPWM_IW-1:0]  imask;
  logic                 out_q;
  logic                 shot_done;
  logic                 flt_s1;
  logic                 flt_s2;
  logic                 flt_d;
  logic                 mode_wr;
  logic                 run;
  // compare datapath
  logic [15:0]          count;
  logic                 period_hit;
  logic                 hit_pri;
  logic                 hit_sec;
  logic                 next_out;
  logic                 next_done;
  logic                 fault_fall;
  logic                 ev_cmp;
  logic                 ev_fault;
  logic [OCPWM_IW-1:0]  ev;

  function automatic logic pwm_start(input logic [15:0] pri);
    return pri != OCPWM_ZERO;
  endfunction

  // start level of the pin for the mode being written
  function automatic logic entry_level(input logic [2:0] mode, input logic cur,
                                       input logic [15:0] pri);
    logic lvl;
    lvl = 1'b0;
    case (mode)
      OCPWM_M_FALL:              lvl = 1'b1;
      OCPWM_M_TOGGLE:            lvl = cur;
      OCPWM_M_PWM, OCPWM_M_PWMF: lvl = pwm_start(pri);
      default:                   lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // which pin edges raise the compare event in each mode
  function automatic logic pin_event(input logic [2:0] mode, input logic nxt,
                                     input logic cur);
    logic hit;
    hit = 1'b0;
    case (mode)
      OCPWM_M_RISE:                 hit = nxt && !cur;
      OCPWM_M_FALL:                 hit = !nxt && cur;
      OCPWM_M_TOGGLE:               hit = nxt != cur;
      OCPWM_M_SINGLE, OCPWM_M_CONT: hit = !nxt && cur;
      default:                      hit = 1'b0;
    endcase
    return hit;
  endfunction

  assign mode_wr    = wr && addr == OCPWM_A_CTRL;
  // time base and its period strobe follow one select bit
  assign count      = timebase_select ? timebase_three : timebase_two;
  assign period_hit = timebase_select ? period_three : period_two;
  // idle halt freezes matches and duty reloads; the counters are not ours
  assign run        = !(idle_halt_bit && cpu_idle);
  assign hit_pri    = run && count == primary_compare_value;
  assign hit_sec    = run && count == secondary_compare_value;
  // first stage feeds only the second
  assign fault_fall = flt_d && !flt_s2;

  // fault pin choice by channel number
  // reset to the idle high level, so release of reset is no fault edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flt_s1 <= 1'b1;
      flt_s2 <= 1'b1;
      flt_d  <= 1'b1;
    end else begin
      flt_s1 <= (CHANNEL <= 4) ? fault_input_a : fault_input_b;
      flt_s2 <= flt_s1;
      flt_d  <= flt_s2;
    end
  end

  // control fields; writes assume the timer is stopped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_select_field <= OCPWM_M_OFF;
      timebase_select   <= 1'b0;
      idle_halt_bit     <= 1'b0;
    end else if (mode_wr) begin
      mode_select_field <= wdata[OCPWM_B_MODE_LO +: 3];
      timebase_select   <= wdata[OCPWM_B_TSEL];
      idle_halt_bit     <= wdata[OCPWM_B_SIDL];
    end
  end

  // compare values
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      primary_compare_value   <= OCPWM_RST_WORD;
      secondary_compare_value <= OCPWM_RST_WORD;
    end else if (wr) begin
      if (addr == OCPWM_A_PRI) begin
        primary_compare_value <= wdata;
      end else if (addr == OCPWM_A_SEC) begin
        secondary_compare_value <= wdata;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      imask <= '0;
    end else if (wr && addr == OCPWM_A_IMASK) begin
      imask <= wdata[OCPWM_IW-1:0];
    end
  end

  // pwm duty shadow, reloaded at each period boundary outside idle halt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      duty <= OCPWM_RST_WORD;
    end else if (mode_wr || (run && period_hit)) begin
      duty <= secondary_compare_value;
    end
  end

  // fault flag: a mode write clears it, but a fault in the same cycle wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fault_status_flag <= 1'b0;
    end else if (mode_select_field == OCPWM_M_PWMF && fault_fall) begin
      fault_status_flag <= 1'b1;
    end else if (mode_wr) begin
      fault_status_flag <= 1'b0;
    end
  end

  // output next state
  always_comb begin
    next_out  = out_q;
    next_done = shot_done;
    case (mode_select_field)
      OCPWM_M_OFF: begin
        next_out  = 1'b0;
        next_done = 1'b0;
      end
      OCPWM_M_RISE: begin
        if (hit_pri) begin
          next_out = 1'b1;
        end
      end
      OCPWM_M_FALL: begin
        if (hit_pri) begin
          next_out = 1'b0;
        end
      end
      OCPWM_M_TOGGLE: begin
        if (hit_pri) begin
          next_out = !out_q;
        end
      end
      OCPWM_M_SINGLE: begin
        if (hit_sec && out_q) begin
          next_out  = 1'b0;
          next_done = 1'b1;
        end else if (hit_pri && !shot_done) begin
          next_out = 1'b1;
        end
      end
      OCPWM_M_CONT: begin
        if (hit_sec && out_q) begin
          next_out = 1'b0;
        end else if (hit_pri) begin
          next_out = 1'b1;
        end
      end
      default: begin
        // pwm: high from period start until count equals duty
        if (mode_select_field == OCPWM_M_PWMF && fault_status_flag) begin
          next_out = 1'b0;
        end else if (run && period_hit) begin
          next_out = secondary_compare_value != OCPWM_ZERO;
        end else if (run && count == duty) begin
          next_out = 1'b0;
        end
      end
    endcase
  end

  // entry into a mode sets the initial pin level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_q <= 1'b0;
    end else if (mode_wr) begin
      out_q <= entry_level(wdata[OCPWM_B_MODE_LO +: 3], out_q, primary_compare_value);
    end else begin
      out_q <= next_out;
    end
  end

  // one-shot latch, rearmed by every mode write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shot_done <= 1'b0;
    end else if (mode_wr) begin
      shot_done <= 1'b0;
    end else begin
      shot_done <= next_done;
    end
  end

  // events from pin edges; the edge made by a mode write itself is no event
  always_comb begin
    ev_cmp            = pin_event(mode_select_field, next_out, out_q) && !mode_wr;
    ev_fault          = mode_select_field == OCPWM_M_PWMF && fault_fall;
    ev                = '0;
    ev[OCPWM_I_CMP]   = ev_cmp;
    ev[OCPWM_I_FAULT] = ev_fault;
  end

  // write-one clear; an event in the same cycle still sets its bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      istat <= '0;
    end else if (wr && addr == OCPWM_A_ISTAT) begin
      istat <= (istat & ~wdata[OCPWM_IW-1:0]) | ev;
    end else begin
      istat <= istat | ev;
    end
  end

  // level interrupt, one clock behind the status
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat & imask);
    end
  end

  // registered so the pin never shows a glitch from the match logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      compare_output_pin <= 1'b0;
    end else begin
      compare_output_pin <= out_q;
    end
  end

  // the port takes the pin back one clock after the mode turns off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_owned <= 1'b0;
    end else begin
      pin_owned <= mode_select_field != OCPWM_M_OFF;
    end
  end

  // read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= OCPWM_RST_WORD;
    end else begin
      rdata <= OCPWM_RST_WORD;
      if (rd) begin
        if (addr == OCPWM_A_CTRL) begin
          rdata[OCPWM_B_MODE_LO +: 3] <= mode_select_field;
          rdata[OCPWM_B_TSEL]         <= timebase_select;
          rdata[OCPWM_B_FLT]          <= fault_status_flag;
          rdata[OCPWM_B_SIDL]         <= idle_halt_bit;
        end else if (addr == OCPWM_A_PRI) begin
          rdata <= primary_compare_value;
        end else if (addr == OCPWM_A_SEC) begin
          rdata <= secondary_compare_value;
        end else if (addr == OCPWM_A_ISTAT) begin
          rdata[OCPWM_IW-1:0] <= istat;
        end else if (addr == OCPWM_A_IMASK) begin
          rdata[OCPWM_IW-1:0] <= imask;
        end else if (addr == OCPWM_A_OUT) begin
          rdata[0] <= out_q;
        end
      end
    end
  end
endmodule

// File: testbench/ocpwm_asserts.sv
/*
  ocpwm_asserts: port-level checks of the compare channel.
  assumes the timer is stopped whenever the control word is written.
*/
`timescale 1ns/10ps
module ocpwm_asserts
  import ocpwm_pkg::*;
(
  input wire logic                           mclk,
  input wire logic                           rst,
  input wire logic [ocpwm_pkg::OCPWM_AW-1:0] addr,
  input wire logic [ocpwm_pkg::OCPWM_DW-1:0] wdata,
  input wire logic                           wr,
  input wire logic                           rd,
  input wire logic [ocpwm_pkg::OCPWM_DW-1:0] rdata,
  input wire logic                           compare_output_pin,
  input wire logic                           pin_owned,
  input wire logic                           irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence ctrl_wr(logic [2:0] m);
    wr && addr == OCPWM_A_CTRL && wdata[2:0] == m;
  endsequence
  sequence ctrl_wr_rd;
    wr && addr == OCPWM_A_CTRL ##2 rd && addr == OCPWM_A_CTRL;
  endsequence
  // pin shows the start level two edges after the write
  property init_lvl(logic [2:0] m, logic lvl);
    ctrl_wr(m) |-> ##2 compare_output_pin == lvl;
  endproperty
  rdata_idle_a: assert property (!$past(rd) |-> rdata == OCPWM_ZERO)
    else $error("read data not zero outside read slot");
  ctrl_unimpl_a: assert property ($past(rd) && $past(addr) == OCPWM_A_CTRL |->
    rdata[15:14] == 2'h0 && rdata[12:5] == 8'h00) else $error("unimplemented bit set");
  unmapped_rd_a: assert property ($past(rd) && $past(addr) > 3'h5 |->
    rdata == OCPWM_ZERO) else $error("unmapped read not zero");
  ctrl_echo_a: assert property (ctrl_wr_rd |=>
    {rdata[13], rdata[3:0]} == {$past(wdata[13], 3), $past(wdata[3:0], 3)})
    else $error("control readback differs");
  rise_init_a: assert property (init_lvl(3'h1, 1'b0)) else $error("start level wrong");
  fall_init_a: assert property (init_lvl(3'h2, 1'b1)) else $error("start level wrong");
  delay_init_a: assert property (init_lvl(3'h4, 1'b0)) else $error("start level wrong");
  train_init_a: assert property (init_lvl(3'h5, 1'b0)) else $error("start level wrong");
  off_owned_a: assert property (ctrl_wr(3'h0) |-> ##2 !pin_owned)
    else $error("pin still owned when off");
  on_owned_a: assert property (wr && addr == OCPWM_A_CTRL && wdata[2:0] != 3'h0 |->
    ##2 pin_owned) else $error("pin not owned when on");
  irq_mask_a: assert property (wr && addr == OCPWM_A_IMASK && wdata[1:0] == 2'h0 |->
    ##2 !irq) else $error("masked interrupt still high");
endmodule

bind ocpwm_channel ocpwm_asserts u_chk (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .compare_output_pin(compare_output_pin),
  .pin_owned(pin_owned), .irq(irq));

// File: testbench/ocpwm_load.sv
/*
  ocpwm_load: the circuit hung on the compare pin; counts its edges.
  assumes the pin is sampled on mclk.
*/
`timescale 1ns/10ps
module ocpwm_load (
  input  wire logic mclk,
  input  wire logic pin,
  output int        rise_cnt,
  output int        fall_cnt
);
  logic last = 1'b0;
  always @(posedge mclk) begin
    if (pin === 1'b1 && last === 1'b0) rise_cnt++;
    if (pin === 1'b0 && last === 1'b1) fall_cnt++;
    last = pin;
  end
endmodule

// File: testbench/ocpwm_channel_tb.sv
/*
  ocpwm_channel_tb: self-checking bench for the compare channel.
  assumes channel 1, so fault input a is the live one.
*/
`timescale 1ns/10ps
module ocpwm_channel_tb;
  import ocpwm_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tmr_on = 1'b0, rd_d = 1'b0;
  logic        p2 = 1'b0, p3 = 1'b0, cpu_idle = 1'b0, flt_a = 1'b1, flt_b = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000, c2 = 16'h0000, c3 = 16'h0000, rdata;
  logic        pin, owned, irq;
  logic [5:1]  init_lvl = 5'b00010, fin_lvl = 5'b00101;
  logic [15:0] exp_q[$], msk_q[$];
  int          n_errors = 0, num_checks = 0, rises, falls, seed = 87, r0;
  always #12.5 mclk = ~mclk;
  ocpwm_channel #(.CHANNEL(1)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .timebase_two(c2), .timebase_three(c3),
    .period_two(p2), .period_three(p3), .cpu_idle(cpu_idle), .fault_input_a(flt_a),
    .fault_input_b(flt_b), .compare_output_pin(pin), .pin_owned(owned), .irq(irq));
  ocpwm_load load (.mclk(mclk), .pin(pin), .rise_cnt(rises), .fall_cnt(falls));
  // stopped timers sit at zero so a control write never lands on a match
  always @(posedge mclk) begin
    c2 <= (!tmr_on || c2 == 16'h0027) ? 16'h0000 : c2 + 16'h0001;
    c3 <= (!tmr_on || c3 == 16'h003b) ? 16'h0000 : c3 + 16'h0001;
    p2 <= tmr_on && c2 == 16'h0027;
    p3 <= tmr_on && c3 == 16'h003b;
    rd_d <= rd;
  end
  always @(negedge mclk) begin
    if (rd_d) chk(rdata & msk_q.pop_front(), exp_q.pop_front());
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  task automatic pchk(input logic e_pin, input logic e_irq);
    // pin and irq trail their cause by one register, so let one more edge pass
    @(posedge mclk);
    @(negedge mclk);
    chk({14'h0000, pin, irq}, {14'h0000, e_pin, e_irq});
  endtask
  task automatic run(input int n, input logic idle = 1'b0);
    @(posedge mclk);
    tmr_on <= 1'b1;
    cpu_idle <= idle;
    repeat (n) @(posedge mclk);
    tmr_on <= 1'b0;
    cpu_idle <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // whole run is under 3000 cycles; 5000 leaves room
  initial begin
    #125000;
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rreg(i[2:0], 16'h0000);
    r0 = $random(seed);
    wreg(OCPWM_A_PRI, r0[15:0]);
    wreg(OCPWM_A_SEC, ~r0[15:0]);
    rreg(OCPWM_A_PRI, r0[15:0]);
    rreg(OCPWM_A_SEC, ~r0[15:0]);
    wreg(OCPWM_A_CTRL, 16'hffff);
    rreg(OCPWM_A_CTRL, 16'h200f);
    $display("done: registers");
    wreg(OCPWM_A_PRI, 16'h000a);
    wreg(OCPWM_A_SEC, 16'h0014);
    wreg(OCPWM_A_IMASK, 16'h0001);
    for (int m = 1; m < 6; m++) begin
      wreg(OCPWM_A_ISTAT, 16'h0003);
      wreg(OCPWM_A_CTRL, m[15:0]);
      rreg(OCPWM_A_OUT, {15'h0000, init_lvl[m]}, 16'h0001);
      run(45);
      pchk(fin_lvl[m], 1'b1);
      rreg(OCPWM_A_ISTAT, 16'h0001);
    end
    r0 = falls;
    run(125);
    chk(16'(falls - r0), 16'h0003);
    wreg(OCPWM_A_IMASK, 16'h0000);
    pchk(1'b0, 1'b0);
    wreg(OCPWM_A_IMASK, 16'h0001);
    pchk(1'b0, 1'b1);
    wreg(OCPWM_A_ISTAT, 16'h0001);
    pchk(1'b0, 1'b0);
    $display("done: compare modes");
    wreg(OCPWM_A_PRI, 16'h0032);
    for (int s = 0; s < 2; s++) begin
      wreg(OCPWM_A_CTRL, {12'h000, s[0], 3'h1});
      run(65, 1'b1);
      pchk(s[0], s[0]);
      wreg(OCPWM_A_ISTAT, 16'h0001);
    end
    wreg(OCPWM_A_CTRL, 16'h0000);
    run(65);
    pchk(1'b0, 1'b0);
    chk({15'h0000, owned}, 16'h0000);
    wreg(OCPWM_A_PRI, 16'h000a);
    wreg(OCPWM_A_CTRL, 16'h2001);
    run(45, 1'b1);
    pchk(1'b0, 1'b0);
    run(45);
    pchk(1'b1, 1'b1);
    $display("done: select, off, idle");
    wreg(OCPWM_A_ISTAT, 16'h0003);
    wreg(OCPWM_A_IMASK, 16'h0003);
    for (int p = 0; p < 2; p++) begin
      wreg(OCPWM_A_PRI, {15'h0000, p[0]});
      wreg(OCPWM_A_CTRL, 16'h0006);
      rreg(OCPWM_A_OUT, {15'h0000, p[0]});
    end
    @(negedge mclk);
    r0 = rises;
    run(100);
    chk(16'(rises - r0), 16'h0002);
    rreg(OCPWM_A_ISTAT, 16'h0000);
    wreg(OCPWM_A_CTRL, 16'h0007);
    flt_b <= 1'b0;
    run(20);
    rreg(OCPWM_A_CTRL, 16'h0007);
    flt_a <= 1'b0;
    run(20);
    pchk(1'b0, 1'b1);
    rreg(OCPWM_A_CTRL, 16'h0017);
    rreg(OCPWM_A_ISTAT, 16'h0002);
    flt_a <= 1'b1;
    flt_b <= 1'b1;
    wreg(OCPWM_A_CTRL, 16'h0007);
    rreg(OCPWM_A_CTRL, 16'h0007);
    $display("done: pwm and fault");
    repeat (3) @(posedge mclk);
    finish_test;
  end
endmodule
